// *** hw/itwd_consts.svh ***
// Offsets, field positions, reset values and timing figures of the interval timer
`ifndef ITWD_CONSTS_SVH
`define ITWD_CONSTS_SVH

`define ITWD_ADR_W 8
`define ITWD_OFS_STATUS 8'h00
`define ITWD_OFS_CONTROL 8'h04
`define ITWD_OFS_PERIOD_LO 8'h08
`define ITWD_OFS_PERIOD_HI 8'h0C
`define ITWD_OFS_SNAP_LO 8'h10
`define ITWD_OFS_SNAP_HI 8'h14
`define ITWD_OFS_EVT_CLEAR 8'h18
`define ITWD_OFS_EVT_ENABLE 8'h1C

`define ITWD_ST_ZERO 0
`define ITWD_ST_RUN 1
`define ITWD_CT_IRQ_EN 0
`define ITWD_CT_CONT 1
`define ITWD_CT_START 2
`define ITWD_CT_STOP 3

`define ITWD_UNIT_CLOCKS 0
`define ITWD_UNIT_USEC 1
`define ITWD_UNIT_MSEC 2
`define ITWD_UNIT_SEC 3
`define ITWD_USEC_PER_SEC 1_000_000
`define ITWD_MSEC_PER_SEC 1_000
`define ITWD_NS_PER_SEC 1_000_000_000
`define ITWD_CLK_PERIOD_NS 20
`define ITWD_TIMEOUT_VALUE 1
`define ITWD_TIMEOUT_UNIT `ITWD_UNIT_MSEC
`define ITWD_UNMAPPED_DATA 32'h0000_0000

`endif

// *** hw/itwd_pkg.sv ***
// Types shared by the interval timer and its users
package itwd_pkg;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } itwd_wb_req_s;

    typedef enum logic {
        ITWD_STOPPED,
        ITWD_RUNNING
    } itwd_run_e;

    typedef logic [31:0] itwd_count_t;
endpackage : itwd_pkg

// *** hw/itwd_timer.sv ***
// Interval timer with watchdog, snapshot and pulse options behind a Wishbone slave
//
// Notes on behaviour
// - 32-bit counter and period, seen through 16-bit wide registers.
// - Control register starts, stops and enables the interrupt.
// - Control bit selects single or continuous count-down.
// - Status register shows zero event and running state.
// - Period is written as low and high halves, used combined.
// - Counter decrements; on zero it reloads from period at once.
// - Writing a snapshot register latches the whole counter coherently.
// - Zero reached with interrupt enabled raises the interrupt.
// - Pulse output high exactly one clock on each zero event.
// - Watchdog zero event asserts unmaskable reset request.
// - Timeout parameter sets the period value after reset.
// - Fixed period: no period registers, period not changeable.
// - Time units convert to smallest whole cycle count not shorter.
// - Strobe output absent (held low) when pulse option is off.
// - Watchdog comes out of reset stopped; once started never stops.
// - Watchdog period write restarts countdown; with fixed period the written value is discarded, else it loads the period.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "itwd_consts.svh"

module itwd_timer #(
    parameter bit WRITEABLE_PERIOD = 1'b1,
    parameter bit READABLE_SNAPSHOT = 1'b1,
    parameter bit START_STOP = 1'b1,
    parameter bit PULSE_EN = 1'b1,
    parameter bit WATCHDOG_EN = 1'b0,
    parameter longint unsigned CLK_HZ = 64'(`ITWD_NS_PER_SEC / `ITWD_CLK_PERIOD_NS),
    parameter longint unsigned TIMEOUT_VALUE = `ITWD_TIMEOUT_VALUE,
    parameter int TIMEOUT_UNIT = `ITWD_TIMEOUT_UNIT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire itwd_pkg::itwd_wb_req_s wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    output logic timeout_strobe_o,
    output logic reset_req_o
);
    import itwd_pkg::*;

    function automatic longint unsigned itwd_cycles(longint unsigned v, int unit);
        longint unsigned div;
        div = 64'd1;
        if (unit == `ITWD_UNIT_USEC) begin
            div = 64'(`ITWD_USEC_PER_SEC);
        end else if (unit == `ITWD_UNIT_MSEC) begin
            div = 64'(`ITWD_MSEC_PER_SEC);
        end
        if (unit == `ITWD_UNIT_CLOCKS) begin
            return v;
        end
        return (v * CLK_HZ + div - 1) / div;
    endfunction : itwd_cycles

    // Period register holds the reload value; one full period is that value plus one clock
    localparam longint unsigned PERIOD_CYCLES = itwd_cycles(TIMEOUT_VALUE, TIMEOUT_UNIT);
    localparam itwd_count_t PERIOD_RST = itwd_count_t'(PERIOD_CYCLES - 1);
    localparam itwd_run_e RUN_RST = (START_STOP || WATCHDOG_EN) ? ITWD_STOPPED : ITWD_RUNNING;

    itwd_count_t cnt_q, cnt_d;
    itwd_count_t period_q, period_d;
    itwd_count_t snap_q, snap_d;
    itwd_run_e run_q, run_d;
    logic cont_q, cont_d;
    logic irq_en_q, irq_en_d;
    logic zero_q, zero_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic strobe_q, strobe_d;
    logic rreq_q, rreq_d;

    logic req;
    logic wr;
    logic zero_evt;
    logic [31:0] rdata;

    assign req = wb_req_i.cyc && wb_req_i.stb;
    assign wr = req && wb_req_i.we && ack_q;
    assign zero_evt = (run_q == ITWD_RUNNING) && (cnt_q == '0);

    // Bus slave: ack one cycle after the request, write commits on the acked edge
    always_comb begin
        ack_d = req && !ack_q;
        rdata = `ITWD_UNMAPPED_DATA;
        unique case (wb_req_i.adr)
            `ITWD_OFS_STATUS: begin
                rdata[`ITWD_ST_ZERO] = zero_q;
                rdata[`ITWD_ST_RUN] = (run_q == ITWD_RUNNING);
            end
            `ITWD_OFS_CONTROL: begin
                rdata[`ITWD_CT_IRQ_EN] = irq_en_q;
                rdata[`ITWD_CT_CONT] = cont_q;
            end
            `ITWD_OFS_EVT_ENABLE: begin
                rdata[`ITWD_ST_ZERO] = irq_en_q;
            end
            `ITWD_OFS_PERIOD_LO: begin
                rdata[15:0] = WRITEABLE_PERIOD ? period_q[15:0] : 16'h0000;
            end
            `ITWD_OFS_PERIOD_HI: begin
                rdata[15:0] = WRITEABLE_PERIOD ? period_q[31:16] : 16'h0000;
            end
            `ITWD_OFS_SNAP_LO: begin
                rdata[15:0] = READABLE_SNAPSHOT ? snap_q[15:0] : 16'h0000;
            end
            `ITWD_OFS_SNAP_HI: begin
                rdata[15:0] = READABLE_SNAPSHOT ? snap_q[31:16] : 16'h0000;
            end
            default: begin
                rdata = `ITWD_UNMAPPED_DATA;
            end
        endcase
        dat_d = (req && !ack_q) ? rdata : dat_q;
    end

    // Counter, period, control and event state
    always_comb begin
        logic period_wr;
        logic ctl_wr;
        period_wr = wr && wb_req_i.sel[1:0] != 2'b00
            && (wb_req_i.adr == `ITWD_OFS_PERIOD_LO || wb_req_i.adr == `ITWD_OFS_PERIOD_HI);
        ctl_wr = wr && wb_req_i.sel[0] && wb_req_i.adr == `ITWD_OFS_CONTROL;
        cnt_d = cnt_q;
        period_d = period_q;
        snap_d = snap_q;
        run_d = run_q;
        cont_d = cont_q;
        irq_en_d = irq_en_q;
        zero_d = zero_q;
        strobe_d = PULSE_EN && zero_evt;
        rreq_d = WATCHDOG_EN && zero_evt;

        if (zero_evt) begin
            cnt_d = period_q;
            if (START_STOP && !WATCHDOG_EN && !cont_q) begin
                run_d = ITWD_STOPPED;
            end
        end else if (run_q == ITWD_RUNNING) begin
            cnt_d = cnt_q - 32'h0000_0001;
        end

        if (ctl_wr) begin
            irq_en_d = wb_req_i.dat[`ITWD_CT_IRQ_EN];
            cont_d = wb_req_i.dat[`ITWD_CT_CONT];
            if (wb_req_i.dat[`ITWD_CT_STOP] && START_STOP && !WATCHDOG_EN) begin
                run_d = ITWD_STOPPED;
            end
            // Start resumes from the current count, no reload
            if (wb_req_i.dat[`ITWD_CT_START] && (START_STOP || WATCHDOG_EN)) begin
                run_d = ITWD_RUNNING;
            end
        end
        if (wr && wb_req_i.sel[0] && wb_req_i.adr == `ITWD_OFS_EVT_ENABLE) begin
            irq_en_d = wb_req_i.dat[`ITWD_ST_ZERO];
        end

        if (period_wr) begin
            if (WRITEABLE_PERIOD) begin
                if (wb_req_i.adr == `ITWD_OFS_PERIOD_LO) begin
                    if (wb_req_i.sel[0]) period_d[7:0] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) period_d[15:8] = wb_req_i.dat[15:8];
                end else begin
                    if (wb_req_i.sel[0]) period_d[23:16] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) period_d[31:24] = wb_req_i.dat[15:8];
                end
                cnt_d = period_d;
            end else if (WATCHDOG_EN) begin
                // Kick: written value dropped, countdown restarts
                cnt_d = period_q;
            end
        end

        if (READABLE_SNAPSHOT && wr && wb_req_i.sel[1:0] != 2'b00
            && (wb_req_i.adr == `ITWD_OFS_SNAP_LO || wb_req_i.adr == `ITWD_OFS_SNAP_HI)) begin
            snap_d = cnt_q;
        end

        // Set wins over a clear in the same cycle
        if (wr && wb_req_i.sel[0] && wb_req_i.adr == `ITWD_OFS_EVT_CLEAR
            && wb_req_i.dat[`ITWD_ST_ZERO]) begin
            zero_d = 1'b0;
        end
        if (zero_evt) begin
            zero_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= PERIOD_RST;
            period_q <= PERIOD_RST;
            snap_q <= '0;
            run_q <= RUN_RST;
            cont_q <= 1'b0;
            irq_en_q <= 1'b0;
            zero_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= '0;
            strobe_q <= 1'b0;
            rreq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            period_q <= period_d;
            snap_q <= snap_d;
            run_q <= run_d;
            cont_q <= cont_d;
            irq_en_q <= irq_en_d;
            zero_q <= zero_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            strobe_q <= strobe_d;
            rreq_q <= rreq_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_o = zero_q && irq_en_q;
    assign timeout_strobe_o = strobe_q;
    assign reset_req_o = rreq_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_zero_reload: assert property (
        zero_evt |=> cnt_q == $past(period_q) || $past(wr))
        else $error("counter not reloaded on zero");
    a_count_down: assert property (
        run_q == ITWD_RUNNING && cnt_q != '0 && !wr |=> cnt_q == $past(cnt_q) - 32'h0000_0001)
        else $error("counter did not decrement");
    a_strobe_width: assert property (
        timeout_strobe_o |=> !timeout_strobe_o)
        else $error("strobe longer than one clock");
    a_strobe_cause: assert property (
        zero_evt |=> timeout_strobe_o == PULSE_EN)
        else $error("strobe does not follow zero event");
    a_reset_req: assert property (
        reset_req_o == (WATCHDOG_EN && $past(zero_evt)))
        else $error("reset request mismatch");
    a_irq_level: assert property (
        zero_evt && irq_en_q && !wr |=> irq_o)
        else $error("interrupt missing after zero");
    a_single_stop: assert property (
        zero_evt && START_STOP && !WATCHDOG_EN && !cont_q && !wr |=> run_q == ITWD_STOPPED)
        else $error("single mode kept running");
    a_wdog_nostop: assert property (
        WATCHDOG_EN && run_q == ITWD_RUNNING |=> run_q == ITWD_RUNNING)
        else $error("watchdog stopped after start");
    a_ack_latency: assert property (
        $rose(req) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    a_snap_copy: assert property (
        READABLE_SNAPSHOT && wr && wb_req_i.adr == `ITWD_OFS_SNAP_LO && wb_req_i.sel[0]
        |=> snap_q == $past(cnt_q))
        else $error("snapshot not coherent");
    a_fixed_period: assert property (
        !WRITEABLE_PERIOD |-> period_q == PERIOD_RST)
        else $error("fixed period changed");

    // Event flag, run control, bus, pulse, watchdog and period write checks
    a_zero_sticky: assert property (
        zero_evt |=> zero_q)
        else $error("zero event not recorded");
    a_clear_event: assert property (
        wr && wb_req_i.adr == `ITWD_OFS_EVT_CLEAR && wb_req_i.sel[0]
        && wb_req_i.dat[`ITWD_ST_ZERO] && !zero_evt |=> !zero_q)
        else $error("zero event not cleared");
    a_stop_holds: assert property (
        run_q == ITWD_STOPPED && !wr |=> run_q == ITWD_STOPPED && $stable(cnt_q))
        else $error("stopped timer moved");
    a_run_start: assert property (
        wr && wb_req_i.adr == `ITWD_OFS_CONTROL && wb_req_i.sel[0]
        && wb_req_i.dat[`ITWD_CT_START] && (START_STOP || WATCHDOG_EN)
        |=> run_q == ITWD_RUNNING)
        else $error("start bit ignored");
    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one clock");
    a_read_upper: assert property (
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data beyond 16 bits");
    a_pulse_absent: assert property (
        !PULSE_EN |-> !timeout_strobe_o)
        else $error("strobe present without pulse option");
    a_wdog_reset: assert property (
        WATCHDOG_EN && $fell(rst_i) |-> run_q == ITWD_STOPPED)
        else $error("watchdog running out of reset");
    a_wdog_restart: assert property (
        WATCHDOG_EN && !WRITEABLE_PERIOD && wr && wb_req_i.sel[1:0] != 2'b00
        && (wb_req_i.adr == `ITWD_OFS_PERIOD_LO || wb_req_i.adr == `ITWD_OFS_PERIOD_HI)
        |=> cnt_q == $past(period_q))
        else $error("watchdog not restarted by period write");
    a_period_write: assert property (
        WRITEABLE_PERIOD && wr && wb_req_i.adr == `ITWD_OFS_PERIOD_LO
        && wb_req_i.sel[1:0] == 2'b11
        |=> period_q[15:0] == $past(wb_req_i.dat[15:0]))
        else $error("period low half not written");
endmodule : itwd_timer

`default_nettype wire

// *** verif/itwd_host.sv ***
// Host bus master model issuing classic Wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module itwd_host (
    input wire logic clk_i,
    output var itwd_pkg::itwd_wb_req_s req_o,
    input wire logic [31:0] dat_i,
    input wire logic ack_i
);
    import itwd_pkg::*;
    logic [31:0] lat;
    logic timed_out;
    initial begin
        req_o = '0;
        lat = '0;
        timed_out = 1'b0;
    end
    // Request held until the edge where ack is seen high, or for at most 16 edges, then released
    task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                          output logic [31:0] rdat);
        lat = '0;
        req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: wdat};
        do begin
            @(posedge clk_i);
            lat = lat + 32'h0000_0001;
        end while (ack_i !== 1'b1 && lat < 32'h0000_0010);
        timed_out = (ack_i !== 1'b1);
        rdat = dat_i;
        req_o <= '0;
        @(posedge clk_i);
    endtask : access
endmodule : itwd_host
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench of the interval timer
`timescale 1ns/1ps
`default_nettype none
`include "itwd_consts.svh"
module tb;
    import itwd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    itwd_wb_req_s req;
    logic [31:0] dat;
    logic ack, irq, strobe;
    logic rreq, ack_wd, irq_wd, strobe_wd, rreq_wd;
    logic [31:0] dat_wd;
    itwd_wb_req_s req_wd;
    int n_errors = 0;
    int total_checks = 0;
    always #10 clk_i = ~clk_i;
    itwd_timer #(.TIMEOUT_VALUE(16), .TIMEOUT_UNIT(`ITWD_UNIT_CLOCKS)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
        .irq_o(irq), .timeout_strobe_o(strobe), .reset_req_o(rreq)
    );
    itwd_host i_host (.clk_i(clk_i), .req_o(req), .dat_i(dat), .ack_i(ack));
    // Watchdog build: 1 us timeout, fixed period, no snapshot, no pulse
    itwd_timer #(
        .WRITEABLE_PERIOD(1'b0), .READABLE_SNAPSHOT(1'b0), .START_STOP(1'b0),
        .PULSE_EN(1'b0), .WATCHDOG_EN(1'b1), .TIMEOUT_VALUE(1),
        .TIMEOUT_UNIT(`ITWD_UNIT_USEC)
    ) i_dut_wd (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req_wd), .wb_dat_o(dat_wd),
        .wb_ack_o(ack_wd), .irq_o(irq_wd), .timeout_strobe_o(strobe_wd),
        .reset_req_o(rreq_wd)
    );
    itwd_host i_host_wd (.clk_i(clk_i), .req_o(req_wd), .dat_i(dat_wd), .ack_i(ack_wd));
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] w,
                       output logic [31:0] r);
        i_host.access(we, a, w, r);
        if (i_host.timed_out) begin
            n_errors++;
            end_of_test();
        end
        // Ack one cycle after the request is seen
        chk(i_host.lat, 32'h0000_0002);
    endtask : acc
    task automatic wd_acc(input logic we, input logic [7:0] a, input logic [31:0] w,
                          output logic [31:0] r);
        i_host_wd.access(we, a, w, r);
        if (i_host_wd.timed_out) begin
            n_errors++;
            end_of_test();
        end
        chk(i_host_wd.lat, 32'h0000_0002);
    endtask : wd_acc
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        logic [31:0] r;
        acc(1'b1, a, w, r);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        acc(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask : rd_chk
    task automatic wait_evt(output logic [31:0] n);
        n = '0;
        do begin
            @(posedge clk_i);
            n = n + 32'h0000_0001;
        end while (strobe !== 1'b1 && n < 32'h0000_0064);
        if (strobe !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask : wait_evt
    task automatic t_reset;
        chk({31'h0, strobe}, 32'h0000_0000);
        rd_chk(`ITWD_OFS_STATUS, 32'h0000_0000);
        rd_chk(`ITWD_OFS_PERIOD_LO, 32'h0000_000F);
        rd_chk(`ITWD_OFS_PERIOD_HI, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
    endtask : t_reset
    task automatic t_cont;
        logic [31:0] n;
        wr(`ITWD_OFS_PERIOD_LO, 32'h0000_0005);
        wr(`ITWD_OFS_CONTROL, 32'h0000_0007);
        wait_evt(n);
        wait_evt(n);
        chk(n, 32'h0000_0006);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, rreq}, 32'h0000_0000);
        @(posedge clk_i);
        rd_chk(`ITWD_OFS_STATUS, 32'h0000_0003);
        wr(`ITWD_OFS_CONTROL, 32'h0000_0008);
        wr(`ITWD_OFS_EVT_CLEAR, 32'h0000_0001);
        rd_chk(`ITWD_OFS_STATUS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask : t_cont
    task automatic t_single;
        logic [31:0] n;
        wr(`ITWD_OFS_CONTROL, 32'h0000_0004);
        wait_evt(n);
        @(posedge clk_i);
        rd_chk(`ITWD_OFS_STATUS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask : t_single
    task automatic t_snap;
        wr(`ITWD_OFS_PERIOD_HI, 32'h0000_0001);
        wr(`ITWD_OFS_PERIOD_LO, 32'h0000_0000);
        wr(`ITWD_OFS_SNAP_HI, 32'h0000_0000);
        rd_chk(`ITWD_OFS_SNAP_LO, 32'h0000_0000);
        rd_chk(`ITWD_OFS_SNAP_HI, 32'h0000_0001);
        rd_chk(`ITWD_OFS_PERIOD_HI, 32'h0000_0001);
    endtask : t_snap
    task automatic t_wdog;
        logic [31:0] r;
        logic [31:0] n;
        wd_acc(1'b0, `ITWD_OFS_STATUS, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        wd_acc(1'b0, `ITWD_OFS_PERIOD_LO, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        wd_acc(1'b0, `ITWD_OFS_SNAP_HI, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        wd_acc(1'b1, `ITWD_OFS_CONTROL, 32'h0000_0005, r);
        wd_acc(1'b1, `ITWD_OFS_CONTROL, 32'h0000_0009, r);
        wd_acc(1'b0, `ITWD_OFS_STATUS, 32'h0000_0000, r);
        chk(r, 32'h0000_0002);
        wd_acc(1'b1, `ITWD_OFS_PERIOD_HI, 32'h0000_1234, r);
        n = '0;
        do begin
            @(posedge clk_i);
            n = n + 32'h0000_0001;
        end while (rreq_wd !== 1'b1 && n < 32'h0000_0064);
        if (rreq_wd !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        // 1 us at 50 MHz is 50 clocks from the kick
        chk(n, 32'h0000_0032);
        chk({31'h0, irq_wd}, 32'h0000_0001);
        @(posedge clk_i);
        chk({30'h0, strobe_wd, rreq_wd}, 32'h0000_0000);
        wd_acc(1'b0, `ITWD_OFS_STATUS, 32'h0000_0000, r);
        chk(r, 32'h0000_0003);
    endtask : t_wdog
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_cont();
        t_single();
        t_snap();
        t_wdog();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
